// *** logic/pvc_pkg.sv ***
// pvc_pkg: register codes, field layouts, reset values and the field carrier
package pvc_pkg;

  // ==========================================================
  // command codes (byte addresses of the register bank)
  localparam logic [7:0] CMD_BUS_PROTOCOL_REVISION = 8'h98;
  localparam logic [7:0] CMD_MAKER_IDENTITY        = 8'h99;
  localparam logic [7:0] CMD_PART_IDENTITY         = 8'hAD;
  localparam logic [7:0] CMD_SILICON_REVISION      = 8'hAE;
  localparam logic [7:0] CMD_PHASE1_BALANCE_GAIN   = 8'hD0;
  localparam logic [7:0] CMD_PHASE2_BALANCE_GAIN   = 8'hD1;
  localparam logic [7:0] CMD_PHASE3_BALANCE_GAIN   = 8'hD2;
  localparam logic [7:0] CMD_OVERCURRENT_LIMIT_DLY = 8'hD6;
  localparam logic [7:0] CMD_ONTIME_FACTOR         = 8'hD7;
  localparam logic [7:0] CMD_QUICK_RESPONSE        = 8'hD8;
  localparam logic [7:0] CMD_THERMAL_HYSTERESIS    = 8'hD9;
  localparam logic [7:0] CMD_RESET_FAULT_POLICY    = 8'hDA;
  localparam logic [7:0] CMD_OVERVOLTAGE_BEHAVIOUR = 8'hDB;
  localparam logic [7:0] CMD_VOLTAGE_SLEW_COMP     = 8'hDC;

  // ==========================================================
  // writable bit masks per byte register
  localparam logic [7:0] MASK_BALANCE_GAIN = 8'h07;
  localparam logic [7:0] MASK_OC_LIMIT_DLY = 8'h0F;
  localparam logic [7:0] MASK_ONTIME       = 8'h0F;
  localparam logic [7:0] MASK_QUICK_RESP   = 8'hFE;
  localparam logic [7:0] MASK_HYSTERESIS   = 8'h07;
  localparam logic [7:0] MASK_POLICY       = 8'h03;
  localparam logic [7:0] MASK_OV_BEHAVIOUR = 8'h03;
  localparam logic [7:0] MASK_SLEW_COMP    = 8'h03;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PROTOCOL_REVISION = 8'h33;
  localparam logic [7:0] RST_BALANCE_GAIN      = 8'h04;
  localparam logic [7:0] RST_OC_LIMIT_DLY      = 8'h05;
  localparam logic [7:0] RST_ONTIME            = 8'h04;
  localparam logic [7:0] RST_QUICK_RESP        = 8'h00;
  localparam logic [7:0] RST_HYSTERESIS        = 8'h01;
  localparam logic [7:0] RST_POLICY            = 8'h01;
  localparam logic [7:0] RST_OV_BEHAVIOUR      = 8'h00;
  localparam logic [7:0] RST_SLEW_COMP         = 8'h01;

  // ==========================================================
  // field positions
  localparam int FAST_OC_LSB   = 2;
  localparam int SLOW_DLY_LSB  = 0;
  localparam int ADAPTIVE_RESPONSE_THRESHOLD_LSB    = 3;
  localparam int QR_WIDTH_LSB  = 1;
  localparam int RESTART_BIT   = 1;
  localparam int ISOLATE_BIT   = 0;
  localparam int ONTIME_HI_BIT = 3;

  // ==========================================================
  // timing: reset pin must be low longer than this
  localparam int RESET_PIN_NS   = 2000;
  localparam int CLK_PERIOD_NS  = 10;
  // longer than: one more than the whole cycle count
  localparam int RESET_PIN_CYC  = RESET_PIN_NS / CLK_PERIOD_NS + 1;

  // over-voltage styles
  typedef enum logic [1:0] {
    PVC_OV_HIZ     = 2'b00,
    PVC_OV_SOFT    = 2'b01,
    PVC_OV_LOWSIDE = 2'b10,
    PVC_OV_UNDEF   = 2'b11
  } pvc_ov_e;

  // decoded settings handed to the analog loop
  typedef struct packed {
    logic [2:0] phase_one_balance_field;
    logic [2:0] phase_two_balance_field;
    logic [2:0] phase_three_balance_field;
    logic [1:0] fast_overcurrent_trip;
    logic [1:0] slow_overcurrent_delay;
    logic [3:0] ontime_factor_field;
    logic       ontime_high_range;
    logic [4:0] adaptive_response_threshold;
    logic       adaptive_response_enable;
    logic [1:0] response_width_limit;
    logic [2:0] thermal_hysteresis;
    logic       restart_on_reset;
    logic       isolate_faulted_channel;
    pvc_ov_e    overvoltage_behaviour;
    logic [1:0] voltage_slew_compensation;
  } pvc_settings_s;

endpackage : pvc_pkg

// *** logic/pvc_cfg_byte.sv ***
// pvc_cfg_byte: one masked read/write configuration byte
module pvc_cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value
);

  // ==========================================================
  // storage; reserved bits keep reset value (zero) and ignore writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value <= RESET_VAL & WR_MASK;
    end else if (wr_en) begin
      value <= wr_data & WR_MASK;
    end
  end

endmodule // pvc_cfg_byte

// *** logic/pvc_config_bank.sv ***
// pvc_config_bank: vendor configuration and identity register bank
module pvc_config_bank #(
  parameter logic [15:0] MAKER_ID   = 16'hA5A5, // arbitrary value
  parameter logic [15:0] PART_ID    = 16'h5A5A, // arbitrary value
  parameter logic [7:0]  SILICON_REV = 8'h03    // arbitrary value
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    wr_en,
  input  wire logic [7:0]              wr_cmd,
  input  wire logic [7:0]              wr_data,
  input  wire logic [7:0]              rd_cmd,
  output logic      [15:0]             rd_data,
  output logic                         rd_hit,
  input  wire logic                    reset_pin_n,
  output logic                         boot_slew_req,
  output logic                         restart_req,
  input  wire logic                    channel_fault,
  output logic                         shutdown_all,
  output logic                         shutdown_faulted,
  output pvc_pkg::pvc_settings_s       settings
);

  // ==========================================================
  // configuration bytes
  logic [7:0] gain1;
  logic [7:0] gain2;
  logic [7:0] gain3;
  logic [7:0] oc_dly;
  logic [7:0] ontime;
  logic [7:0] qresp;
  logic [7:0] hyst;
  logic [7:0] policy;
  logic [7:0] ovb;
  logic [7:0] slew;

  // write strobes per command
  logic we_g1;
  logic we_g2;
  logic we_g3;
  logic we_oc;
  logic we_on;
  logic we_qr;
  logic we_hy;
  logic we_po;
  logic we_ov;
  logic we_sl;

  assign we_g1 = wr_en && wr_cmd == pvc_pkg::CMD_PHASE1_BALANCE_GAIN;
  assign we_g2 = wr_en && wr_cmd == pvc_pkg::CMD_PHASE2_BALANCE_GAIN;
  assign we_g3 = wr_en && wr_cmd == pvc_pkg::CMD_PHASE3_BALANCE_GAIN;
  assign we_oc = wr_en && wr_cmd == pvc_pkg::CMD_OVERCURRENT_LIMIT_DLY;
  assign we_on = wr_en && wr_cmd == pvc_pkg::CMD_ONTIME_FACTOR;
  assign we_qr = wr_en && wr_cmd == pvc_pkg::CMD_QUICK_RESPONSE;
  assign we_hy = wr_en && wr_cmd == pvc_pkg::CMD_THERMAL_HYSTERESIS;
  assign we_po = wr_en && wr_cmd == pvc_pkg::CMD_RESET_FAULT_POLICY;
  assign we_ov = wr_en && wr_cmd == pvc_pkg::CMD_OVERVOLTAGE_BEHAVIOUR;
  assign we_sl = wr_en && wr_cmd == pvc_pkg::CMD_VOLTAGE_SLEW_COMP;

  // ==========================================================
  // register instances
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_BALANCE_GAIN),
    .WR_MASK(pvc_pkg::MASK_BALANCE_GAIN)) u_gain1 (
    .clk(clk), .resetn(resetn), .wr_en(we_g1), .wr_data(wr_data),
    .value(gain1));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_BALANCE_GAIN),
    .WR_MASK(pvc_pkg::MASK_BALANCE_GAIN)) u_gain2 (
    .clk(clk), .resetn(resetn), .wr_en(we_g2), .wr_data(wr_data),
    .value(gain2));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_BALANCE_GAIN),
    .WR_MASK(pvc_pkg::MASK_BALANCE_GAIN)) u_gain3 (
    .clk(clk), .resetn(resetn), .wr_en(we_g3), .wr_data(wr_data),
    .value(gain3));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_OC_LIMIT_DLY),
    .WR_MASK(pvc_pkg::MASK_OC_LIMIT_DLY)) u_ocdly (
    .clk(clk), .resetn(resetn), .wr_en(we_oc), .wr_data(wr_data),
    .value(oc_dly));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_ONTIME),
    .WR_MASK(pvc_pkg::MASK_ONTIME)) u_ontime (
    .clk(clk), .resetn(resetn), .wr_en(we_on), .wr_data(wr_data),
    .value(ontime));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_QUICK_RESP),
    .WR_MASK(pvc_pkg::MASK_QUICK_RESP)) u_qresp (
    .clk(clk), .resetn(resetn), .wr_en(we_qr), .wr_data(wr_data),
    .value(qresp));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_HYSTERESIS),
    .WR_MASK(pvc_pkg::MASK_HYSTERESIS)) u_hyst (
    .clk(clk), .resetn(resetn), .wr_en(we_hy), .wr_data(wr_data),
    .value(hyst));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_POLICY),
    .WR_MASK(pvc_pkg::MASK_POLICY)) u_policy (
    .clk(clk), .resetn(resetn), .wr_en(we_po), .wr_data(wr_data),
    .value(policy));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_OV_BEHAVIOUR),
    .WR_MASK(pvc_pkg::MASK_OV_BEHAVIOUR)) u_ovb (
    .clk(clk), .resetn(resetn), .wr_en(we_ov), .wr_data(wr_data),
    .value(ovb));
  pvc_cfg_byte #(.RESET_VAL(pvc_pkg::RST_SLEW_COMP),
    .WR_MASK(pvc_pkg::MASK_SLEW_COMP)) u_slew (
    .clk(clk), .resetn(resetn), .wr_en(we_sl), .wr_data(wr_data),
    .value(slew));

  // ==========================================================
  // read decode, registered one cycle after rd_cmd
  logic [15:0] next_rd_data;
  logic        next_rd_hit;

  always_comb begin
    next_rd_data = 16'h0000;
    next_rd_hit  = 1'b1;
    case (rd_cmd)
      pvc_pkg::CMD_BUS_PROTOCOL_REVISION:
        next_rd_data = {8'h00, pvc_pkg::RST_PROTOCOL_REVISION};
      pvc_pkg::CMD_MAKER_IDENTITY:   next_rd_data = MAKER_ID;
      pvc_pkg::CMD_PART_IDENTITY:    next_rd_data = PART_ID;
      pvc_pkg::CMD_SILICON_REVISION:
        next_rd_data = {8'h00, SILICON_REV};
      pvc_pkg::CMD_PHASE1_BALANCE_GAIN:   next_rd_data = {8'h00, gain1};
      pvc_pkg::CMD_PHASE2_BALANCE_GAIN:   next_rd_data = {8'h00, gain2};
      pvc_pkg::CMD_PHASE3_BALANCE_GAIN:   next_rd_data = {8'h00, gain3};
      pvc_pkg::CMD_OVERCURRENT_LIMIT_DLY: next_rd_data = {8'h00, oc_dly};
      pvc_pkg::CMD_ONTIME_FACTOR:         next_rd_data = {8'h00, ontime};
      pvc_pkg::CMD_QUICK_RESPONSE:        next_rd_data = {8'h00, qresp};
      pvc_pkg::CMD_THERMAL_HYSTERESIS:    next_rd_data = {8'h00, hyst};
      pvc_pkg::CMD_RESET_FAULT_POLICY:    next_rd_data = {8'h00, policy};
      pvc_pkg::CMD_OVERVOLTAGE_BEHAVIOUR: next_rd_data = {8'h00, ovb};
      pvc_pkg::CMD_VOLTAGE_SLEW_COMP:     next_rd_data = {8'h00, slew};
      default: next_rd_hit = 1'b0; // unmapped reads zero
    endcase
  end

  // read data flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 16'h0000;
      rd_hit  <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_hit  <= next_rd_hit;
    end
  end

  // ==========================================================
  // settings carrier to the analog loop
  always_comb begin
    settings = '0;
    settings.phase_one_balance_field   = gain1[2:0];
    settings.phase_two_balance_field   = gain2[2:0];
    settings.phase_three_balance_field = gain3[2:0];
    settings.fast_overcurrent_trip =
      oc_dly[pvc_pkg::FAST_OC_LSB +: 2];
    settings.slow_overcurrent_delay =
      oc_dly[pvc_pkg::SLOW_DLY_LSB +: 2];
    settings.ontime_factor_field = ontime[3:0];
    settings.ontime_high_range = ontime[pvc_pkg::ONTIME_HI_BIT];
    settings.adaptive_response_threshold =
      qresp[pvc_pkg::ADAPTIVE_RESPONSE_THRESHOLD_LSB +: 5];
    settings.adaptive_response_enable =
      |qresp[pvc_pkg::ADAPTIVE_RESPONSE_THRESHOLD_LSB +: 5];
    settings.response_width_limit =
      qresp[pvc_pkg::QR_WIDTH_LSB +: 2];
    settings.thermal_hysteresis = hyst[2:0];
    settings.restart_on_reset = policy[pvc_pkg::RESTART_BIT];
    settings.isolate_faulted_channel =
      policy[pvc_pkg::ISOLATE_BIT];
    settings.overvoltage_behaviour = pvc_pkg::pvc_ov_e'(ovb[1:0]);
    settings.voltage_slew_compensation = slew[1:0];
  end

  // ==========================================================
  // reset pin low-time counter, saturates past the threshold
  localparam int CW = $clog2(pvc_pkg::RESET_PIN_CYC + 1);
  localparam logic [CW-1:0] HOLD_CYC = CW'(pvc_pkg::RESET_PIN_CYC);
  logic [CW-1:0] low_cnt;
  logic          reset_long;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= '0;
    end else if (reset_pin_n) begin
      low_cnt <= '0;
    end else if (low_cnt != HOLD_CYC) begin
      low_cnt <= low_cnt + CW'(1);
    end
  end

  assign reset_long = (low_cnt == HOLD_CYC);

  // one-cycle action when the low time first passes 2us
  logic reset_long_d;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_long_d  <= 1'b0;
      boot_slew_req <= 1'b0;
      restart_req   <= 1'b0;
    end else begin
      reset_long_d  <= reset_long;
      boot_slew_req <= reset_long && !reset_long_d &&
                       !policy[pvc_pkg::RESTART_BIT];
      restart_req   <= reset_long && !reset_long_d &&
                       policy[pvc_pkg::RESTART_BIT];
    end
  end

  // fault isolation policy, registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_all     <= 1'b0;
      shutdown_faulted <= 1'b0;
    end else begin
      shutdown_all     <= channel_fault &&
                          !policy[pvc_pkg::ISOLATE_BIT];
      shutdown_faulted <= channel_fault &&
                          policy[pvc_pkg::ISOLATE_BIT];
    end
  end

  // ==========================================================
  // checks
  chk_maker_ident: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_cmd == pvc_pkg::CMD_MAKER_IDENTITY |=> rd_data == MAKER_ID)
    else $error("maker identity read wrong");
  chk_part_ident: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_cmd == pvc_pkg::CMD_PART_IDENTITY |=> rd_data == PART_ID)
    else $error("part identity read wrong");
  chk_silicon_rev: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_cmd == pvc_pkg::CMD_SILICON_REVISION
    |=> rd_data == {8'h00, SILICON_REV})
    else $error("silicon revision read wrong");
  chk_gain_write: assert property (
    @(posedge clk) disable iff (!resetn)
    we_g1 |=> settings.phase_one_balance_field == $past(wr_data[2:0]))
    else $error("balance gain not written");
  chk_gain3_write: assert property (
    @(posedge clk) disable iff (!resetn)
    we_g3 |=> settings.phase_three_balance_field == $past(wr_data[2:0]))
    else $error("third balance gain not written");
  chk_fast_oc: assert property (
    @(posedge clk) disable iff (!resetn)
    we_oc |=> settings.fast_overcurrent_trip == $past(wr_data[3:2]))
    else $error("fast trip field wrong");
  chk_slow_dly: assert property (
    @(posedge clk) disable iff (!resetn)
    we_oc |=> settings.slow_overcurrent_delay == $past(wr_data[1:0]))
    else $error("slow delay field wrong");
  chk_ontime_range: assert property (
    @(posedge clk) disable iff (!resetn)
    settings.ontime_high_range == (ontime[3:0] >= 4'h8))
    else $error("on-time range wrong");
  chk_ontime_rsv: assert property (
    @(posedge clk) disable iff (!resetn)
    we_on |=> ontime[7:4] == 4'h0)
    else $error("on-time reserved bits set");
  chk_aqr_enable: assert property (
    @(posedge clk) disable iff (!resetn)
    we_qr && wr_data[7:3] == 5'h00
    |=> !settings.adaptive_response_enable)
    else $error("quick response not disabled");
  chk_qr_width: assert property (
    @(posedge clk) disable iff (!resetn)
    we_qr |=> settings.response_width_limit == $past(wr_data[2:1])
    && qresp[0] == 1'b0)
    else $error("width limit wrong");
  chk_hyst_write: assert property (
    @(posedge clk) disable iff (!resetn)
    we_hy |=> hyst == {5'h00, $past(wr_data[2:0])})
    else $error("hysteresis wrong");
  chk_reset_pin: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(reset_pin_n) && !we_po ##1 (!reset_pin_n)[*8]
    |-> !boot_slew_req && !restart_req)
    else $error("reset action too early");
  chk_pin_high_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    reset_pin_n && $past(reset_pin_n)
    |=> !boot_slew_req && !restart_req)
    else $error("reset action with pin high");
  chk_pulse_single: assert property (
    @(posedge clk) disable iff (!resetn)
    boot_slew_req || restart_req |=> !boot_slew_req && !restart_req)
    else $error("reset action repeated");
  chk_fault_policy: assert property (
    @(posedge clk) disable iff (!resetn)
    channel_fault |=> shutdown_all != shutdown_faulted)
    else $error("fault shutdown not unique");
  chk_fault_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    !channel_fault |=> !shutdown_all && !shutdown_faulted)
    else $error("shutdown without fault");
  chk_policy_write: assert property (
    @(posedge clk) disable iff (!resetn)
    we_po |=> policy == {6'h00, $past(wr_data[1:0])})
    else $error("policy byte wrong");
  chk_ov_style: assert property (
    @(posedge clk) disable iff (!resetn)
    we_ov |=> settings.overvoltage_behaviour == $past(wr_data[1:0]))
    else $error("ov style wrong");
  chk_slew_comp: assert property (
    @(posedge clk) disable iff (!resetn)
    we_sl |=> slew == {6'h00, $past(wr_data[1:0])})
    else $error("slew comp wrong");
  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_cmd == 8'h00 |=> rd_data == 16'h0000 && !rd_hit)
    else $error("unmapped read not zero");
  chk_reserved_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    we_g2 |=> gain2[7:3] == 5'h00 && $stable(gain1))
    else $error("reserved bits written");

endmodule // pvc_config_bank

// *** bench/pvc_host_model.sv ***
// pvc_host_model: host that issues register writes and reads
module pvc_host_model (
  input  wire logic        clk,
  output logic             wr_en,
  output logic [7:0]       wr_cmd,
  output logic [7:0]       wr_data,
  output logic [7:0]       rd_cmd,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_hit
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // idle bus
  initial begin
    wr_en   = 1'b0;
    wr_cmd  = 8'h00;
    wr_data = 8'h00;
    rd_cmd  = 8'h00;
  end

  // ==========================================================
  // one write strobe, launched on the falling edge
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_cmd  = cmd;
    wr_data = data;
    @(negedge clk);
    wr_en   = 1'b0;
    wr_cmd  = ~cmd;  // released lines do not keep their value
    wr_data = ~data;
  endtask

  // address for one edge, collect the answer on the next falling edge
  task automatic read_reg(input  logic [7:0]  cmd,
                          output logic [15:0] data,
                          output logic        hit);
    @(negedge clk);
    rd_cmd = cmd;
    @(negedge clk);
    data = rd_data;
    hit  = rd_hit;
  endtask
endmodule // pvc_host_model

// *** bench/pvc_config_bank_bench.sv ***
// pvc_config_bank_bench: self-checking bench of the configuration bank
`define CHECK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module pvc_config_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // signals
  logic                  clk;
  logic                  resetn;
  logic                  wr_en;
  logic [7:0]            wr_cmd;
  logic [7:0]            wr_data;
  logic [7:0]            rd_cmd;
  logic [15:0]           rd_data;
  logic                  rd_hit;
  logic                  reset_pin_n;
  logic                  boot_slew_req;
  logic                  restart_req;
  logic                  channel_fault;
  logic                  shutdown_all;
  logic                  shutdown_faulted;
  pvc_pkg::pvc_settings_s settings;
  int                    error_cnt = 0;
  int                    n_tests   = 0;
  int                    boot_cnt  = 0;
  int                    rst_cnt   = 0;
  logic [7:0] cfg_cmd [10] = '{8'hD0, 8'hD1, 8'hD2, 8'hD6, 8'hD7,
                               8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC};
  logic [7:0] cfg_rst [10] = '{8'h04, 8'h04, 8'h04, 8'h05, 8'h04,
                               8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
  logic [7:0] cfg_msk [10] = '{8'h07, 8'h07, 8'h07, 8'h0F, 8'h0F,
                               8'hFE, 8'h07, 8'h03, 8'h03, 8'h03};

  // ==========================================================
  // clock and instances
  always #5 clk = ~clk;

  pvc_config_bank u_pvc_config_bank (
    .clk(clk), .resetn(resetn), .wr_en(wr_en), .wr_cmd(wr_cmd),
    .wr_data(wr_data), .rd_cmd(rd_cmd), .rd_data(rd_data),
    .rd_hit(rd_hit), .reset_pin_n(reset_pin_n),
    .boot_slew_req(boot_slew_req), .restart_req(restart_req),
    .channel_fault(channel_fault), .shutdown_all(shutdown_all),
    .shutdown_faulted(shutdown_faulted), .settings(settings)
  );

  pvc_host_model u_pvc_host_model (
    .clk(clk), .wr_en(wr_en), .wr_cmd(wr_cmd), .wr_data(wr_data),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .rd_hit(rd_hit)
  );

  // pulse counters, one count per sampled high cycle
  always @(negedge clk) begin
    if (boot_slew_req === 1'b1) boot_cnt++;
    if (restart_req === 1'b1) rst_cnt++;
  end

  // ==========================================================
  // helpers
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_reg(input logic [7:0] cmd, input logic [15:0] exp,
                           input logic exp_hit);
    logic [15:0] got;
    logic        hit;
    u_pvc_host_model.read_reg(cmd, got, hit);
    `CHECK(got, exp)
    `CHECK(hit, exp_hit)
  endtask

  // reset pin low for n sampling edges, then high again
  task automatic hold_pin(input int n);
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (n) @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    clk           = 1'b0;
    resetn        = 1'b0;
    reset_pin_n   = 1'b1;
    channel_fault = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    // identity words and reset values
    check_reg(8'h98, 16'h0033, 1'b1);
    check_reg(8'h99, 16'hA5A5, 1'b1);
    check_reg(8'hAD, 16'h5A5A, 1'b1);
    check_reg(8'hAE, 16'h0003, 1'b1);
    for (int i = 0; i < 10; i++)
      check_reg(cfg_cmd[i], {8'h00, cfg_rst[i]}, 1'b1);
    `CHECK(settings.adaptive_response_enable, 1'b0)
    `CHECK(settings.isolate_faulted_channel, 1'b1)
    // all ones to every config byte, stray identity writes: only writable fields take them
    for (int i = 0; i < 10; i++)
      u_pvc_host_model.write_reg(cfg_cmd[i], 8'hFF);
    u_pvc_host_model.write_reg(8'h99, 8'h00);
    u_pvc_host_model.write_reg(8'hAD, 8'h00);
    u_pvc_host_model.write_reg(8'hAE, 8'hFF);
    check_reg(8'h99, 16'hA5A5, 1'b1);
    check_reg(8'hAD, 16'h5A5A, 1'b1);
    check_reg(8'hAE, 16'h0003, 1'b1);
    for (int i = 0; i < 10; i++)
      check_reg(cfg_cmd[i], {8'h00, cfg_msk[i]}, 1'b1);
    check_reg(8'h00, 16'h0000, 1'b0);
    `CHECK(settings.phase_three_balance_field, 3'h7)
    `CHECK({settings.phase_one_balance_field,
            settings.phase_two_balance_field}, 6'h3F)
    `CHECK(settings.ontime_factor_field, 4'hF)
    `CHECK(settings.restart_on_reset, 1'b1)
    `CHECK(settings.adaptive_response_threshold, 5'h1F)
    `CHECK(settings.response_width_limit, 2'b11)
    `CHECK(settings.voltage_slew_compensation, 2'b11)
    // on-time range boundary and field positions
    u_pvc_host_model.write_reg(8'hD7, 8'h07);
    `CHECK(settings.ontime_high_range, 1'b0)
    u_pvc_host_model.write_reg(8'hD7, 8'h08);
    `CHECK(settings.ontime_high_range, 1'b1)
    u_pvc_host_model.write_reg(8'hD6, 8'h09);
    `CHECK({settings.fast_overcurrent_trip,
            settings.slow_overcurrent_delay}, 4'h9)
    u_pvc_host_model.write_reg(8'hD8, 8'h06);
    `CHECK(settings.adaptive_response_enable, 1'b0)
    `CHECK(settings.response_width_limit, 2'b11)
    u_pvc_host_model.write_reg(8'hD8, 8'h08);
    `CHECK(settings.adaptive_response_enable, 1'b1)
    `CHECK(settings.thermal_hysteresis, 3'h7)
    for (int j = 0; j < 3; j++) begin
      u_pvc_host_model.write_reg(8'hDB, 8'(j));
      `CHECK(settings.overvoltage_behaviour, 2'(j))
    end
    // reset pin: boot slew path
    u_pvc_host_model.write_reg(8'hDA, 8'h00);
    `CHECK(settings.restart_on_reset, 1'b0)
    hold_pin(200);
    `CHECK(boot_cnt, 0)
    hold_pin(201);
    `CHECK(boot_cnt, 1)
    hold_pin(300);
    `CHECK(boot_cnt, 2)
    `CHECK(rst_cnt, 0)
    // reset pin: restart path
    u_pvc_host_model.write_reg(8'hDA, 8'h02);
    hold_pin(201);
    `CHECK(rst_cnt, 1)
    `CHECK(boot_cnt, 2)
    // channel fault with both isolation policies
    @(negedge clk);
    channel_fault = 1'b1;
    @(negedge clk);
    `CHECK({shutdown_all, shutdown_faulted}, 2'b10)
    u_pvc_host_model.write_reg(8'hDA, 8'h01);
    @(negedge clk);
    `CHECK({shutdown_all, shutdown_faulted}, 2'b01)
    channel_fault = 1'b0;
    @(negedge clk);
    `CHECK({shutdown_all, shutdown_faulted}, 2'b00)
    // second reset restores defaults
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    check_reg(8'hD0, 16'h0004, 1'b1);
    check_reg(8'hDC, 16'h0001, 1'b1);
    wrap_up();
  end
endmodule // pvc_config_bank_bench
